//--- sfbse_pkg.sv
// shared constants and types of the block and sector erase sequencer
// assumes a 10 MHz core clock and a host-made serial clock on the link
package sfbse_pkg;

   // opcodes recognised on the link
   localparam logic [7:0]  OP_BLOCK_ERASE  = 8'h50;
   localparam logic [7:0]  OP_SECTOR_ERASE = 8'h7c;

   // frame layout: one opcode byte then three address bytes, msb first
   localparam int          FRAME_W    = 32;
   localparam logic [5:0]  FRAME_LAST = 6'h1f;   // index of the last bit
   localparam logic [5:0]  FRAME_OVER = 6'h20;   // first bit too many
   localparam int          OPC_MSB    = 31;
   localparam int          OPC_LSB    = 24;

   // page select field in the address bytes, per page mode
   localparam int          SEL264_MSB = 19;      // 4 ignored bits above
   localparam int          SEL264_LSB = 12;      // 12 ignored bits below
   localparam int          SEL256_MSB = 18;      // 5 ignored bits above
   localparam int          SEL256_LSB = 11;      // 11 ignored bits below

   // position of the sector number inside the 8-bit select
   localparam int          SECT_MSB   = 7;
   localparam int          SECT_LSB   = 5;
   localparam logic [2:0]  SECT_ZERO  = 3'h0;

   // array geometry in pages
   localparam int          PAGE_W         = 11;
   localparam int          SEL_W          = 8;
   localparam logic [8:0]  BLOCK_PAGES    = 9'h008;
   localparam logic [8:0]  SECT0A_PAGES   = 9'h008;
   localparam logic [8:0]  SECT0B_PAGES   = 9'h0f8;
   localparam logic [8:0]  SECTOR_PAGES   = 9'h100;
   localparam logic [10:0] SECT0B_FIRST   = 11'h008;
   localparam logic [2:0]  PAGE_IN_BLOCK0 = 3'h0;
   localparam logic [7:0]  PAGE_IN_SECT0  = 8'h00;
   localparam logic [8:0]  ONE_PAGE       = 9'h001;

   // fill value of an erased byte
   localparam logic [7:0]  ERASED_BYTE = 8'hff;

   // core clock period in ns
   localparam int          CLK_PERIOD_NS = 100;
   localparam int          NS_PER_US     = 1000;

   // sequencer states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,   // waiting for a command
      ST_WIPE = 2'b01,   // one page strobe per cycle
      ST_HOLD = 2'b10    // rest of the self-timed interval
   } sfbse_state_e;

endpackage

//--- sfbse_link_if.sv
// carrier between the link-side shifter and the erase sequencer
// assumes the word stays stable from a frame toggle until the next frame
`timescale 1ns/1ps
`default_nettype none
interface sfbse_link_if;
   import sfbse_pkg::*;

   logic [FRAME_W-1:0] frame_word;  // opcode and address of last full frame
   logic               frame_tog;   // flips when 32 bits have arrived
   logic               over_tog;    // flips when a 33rd bit arrives

   modport link (output frame_word, output frame_tog, output over_tog);
   modport core (input  frame_word, input  frame_tog, input  over_tog);
endinterface
`default_nettype wire

//--- sfbse_link.sv
// serial shifter on the host clock: gathers opcode and address bits
// assumes mode 0 or 3: data sampled on the rising serial clock edge
`timescale 1ns/1ps
`default_nettype none
module sfbse_link
   import sfbse_pkg::*;
(
   input  wire logic   reset_n,   // core reset, active low
   input  wire logic   spi_sck,   // host serial clock
   input  wire logic   spi_cs_n,  // chip select, active low
   input  wire logic   spi_si,    // serial data in
   sfbse_link_if.link  lnk        // towards the sequencer
);

   logic [5:0]         bit_cnt_r;   // bits seen in this frame
   logic [FRAME_W-1:0] shift_r;     // incoming bits, msb first
   logic [FRAME_W-1:0] word_r;      // held frame for the core domain
   logic               frame_tog_r; // frame complete event
   logic               over_tog_r;  // frame too long event
   logic               frame_rst_n; // frame reset: idle select clears
   logic [FRAME_W-1:0] shift_nxt;   // shift register next value

   // a raised select ends the frame without needing a clock edge
   assign frame_rst_n = reset_n & ~spi_cs_n;
   assign shift_nxt   = {shift_r[FRAME_W-2:0], spi_si};

   // per-frame counter and shifter, cleared between frames
   always_ff @(posedge spi_sck or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         bit_cnt_r <= 6'h00;
         shift_r   <= '0;
      end else begin
         shift_r <= shift_nxt;
         if (bit_cnt_r != FRAME_OVER + 6'h01)   // saturate past overflow
            bit_cnt_r <= bit_cnt_r + 6'h01;
      end
   end

   // events survive the frame end, so only the core reset clears them
   always_ff @(posedge spi_sck or negedge reset_n) begin
      if (!reset_n) begin
         word_r      <= '0;
         frame_tog_r <= 1'b0;
         over_tog_r  <= 1'b0;
      end else if (!spi_cs_n) begin
         if (bit_cnt_r == FRAME_LAST) begin     // opcode plus 3 bytes
            word_r      <= shift_nxt;
            frame_tog_r <= ~frame_tog_r;
         end
         if (bit_cnt_r == FRAME_OVER)           // more than 3 bytes
            over_tog_r <= ~over_tog_r;
      end
   end

   assign lnk.frame_word = word_r;
   assign lnk.frame_tog  = frame_tog_r;
   assign lnk.over_tog   = over_tog_r;

endmodule // sfbse_link
`default_nettype wire

//--- sfbse_top.sv
// block and sector erase sequencer of a serial flash, core clock side
// assumes the host clocks frames on spi_sck and the array follows the
// page wipe strobes; protection is not handled here
`timescale 1ns/1ps
`default_nettype none

module sfbse_top
   import sfbse_pkg::*;
#(
   parameter int BLOCK_ERASE_MAX_TIME_US  = 1000,  // longest block erase
   parameter int SECTOR_ERASE_MAX_TIME_US = 5000   // longest sector erase
)(
   input  wire logic              clk,           // core clock, 10 MHz
   input  wire logic              reset_n,       // async reset, active low
   input  wire logic              spi_sck,       // host serial clock
   input  wire logic              spi_cs_n,      // chip select, active low
   input  wire logic              spi_si,        // serial data in
   input  wire logic              page_mode_256, // high: 256-byte pages
   output var  logic              busy_n,        // ready/busy pin, low busy
   output var  logic              status_busy,   // status register busy bit
   output var  logic              array_wipe,    // one page to erase now
   output var  logic [PAGE_W-1:0] array_page,    // page being erased
   output var  logic [7:0]        array_fill,    // value written to bytes
   output var  logic              erase_done     // pulse at the end
);

   // cycle budgets, rounded down so the erase ends inside the limit
   localparam int BE_CYC_I = BLOCK_ERASE_MAX_TIME_US * NS_PER_US
                             / CLK_PERIOD_NS;
   localparam int SE_CYC_I = SECTOR_ERASE_MAX_TIME_US * NS_PER_US
                             / CLK_PERIOD_NS;
   localparam logic [31:0] BE_CYC = 32'(BE_CYC_I);
   localparam logic [31:0] SE_CYC = 32'(SE_CYC_I);

   // first page and page count of an erase, packed as {first, count}
   function automatic logic [19:0] erase_span(
      input logic             is_sector,
      input logic [SEL_W-1:0] sel
   );
      logic [2:0]  sect;
      logic [19:0] span;
      sect = sel[SECT_MSB:SECT_LSB];
      span = {sel, PAGE_IN_BLOCK0, BLOCK_PAGES};
      if (is_sector) begin
         if (sect != SECT_ZERO)
            span = {sect, PAGE_IN_SECT0, SECTOR_PAGES};
         else if (sel[0])                                 // sector 0b
            span = {SECT0B_FIRST, SECT0B_PAGES};
         else                                             // sector 0a
            span = {'0, SECT0A_PAGES};
      end
      return span;
   endfunction

   // select field of the address bytes in either page mode
   function automatic logic [SEL_W-1:0] page_select(
      input logic               mode_256,
      input logic [FRAME_W-1:0] word
   );
      logic [SEL_W-1:0] sel;
      if (mode_256)
         sel = word[SEL256_MSB:SEL256_LSB];
      else
         sel = word[SEL264_MSB:SEL264_LSB];
      return sel;
   endfunction

   // link-side shifter on its own clock
   sfbse_link_if lnk ();

   sfbse_link u_link (
      .reset_n  (reset_n),
      .spi_sck  (spi_sck),
      .spi_cs_n (spi_cs_n),
      .spi_si   (spi_si),
      .lnk      (lnk)
   );

   // synchronisers: first stage feeds only the second
   logic       cs_s1_r;     // select, stage 1
   logic       cs_s2_r;     // select, stage 2
   logic       cs_s3_r;     // select, edge history
   logic       cs_s4_r;     // select, delayed edge history
   logic       mode_s1_r;   // page mode, stage 1
   logic       mode_s2_r;   // page mode, stage 2
   logic       frm_s1_r;    // frame toggle, stage 1
   logic       frm_s2_r;    // frame toggle, stage 2
   logic       frm_s3_r;    // frame toggle, history
   logic       ovr_s1_r;    // overflow toggle, stage 1
   logic       ovr_s2_r;    // overflow toggle, stage 2
   logic       ovr_s3_r;    // overflow toggle, history

   // two flops on the select, page mode and link toggle signals; the frame word crosses without them
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cs_s1_r   <= 1'b1;
         cs_s2_r   <= 1'b1;
         cs_s3_r   <= 1'b1;
         cs_s4_r   <= 1'b1;
         mode_s1_r <= 1'b0;
         mode_s2_r <= 1'b0;
      end else begin
         cs_s1_r   <= spi_cs_n;
         cs_s2_r   <= cs_s1_r;
         cs_s3_r   <= cs_s2_r;
         cs_s4_r   <= cs_s3_r;
         mode_s1_r <= page_mode_256;
         mode_s2_r <= mode_s1_r;
      end
   end

   // toggle events from the link domain
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         frm_s1_r <= 1'b0;
         frm_s2_r <= 1'b0;
         frm_s3_r <= 1'b0;
         ovr_s1_r <= 1'b0;
         ovr_s2_r <= 1'b0;
         ovr_s3_r <= 1'b0;
      end else begin
         frm_s1_r <= lnk.frame_tog;
         frm_s2_r <= frm_s1_r;
         frm_s3_r <= frm_s2_r;
         ovr_s1_r <= lnk.over_tog;
         ovr_s2_r <= ovr_s1_r;
         ovr_s3_r <= ovr_s2_r;
      end
   end

   // edges and events, all from synchronised stages
   wire cs_fall  = cs_s3_r & ~cs_s2_r;   // new frame begins
   // the rise is taken one stage late, so a frame event that crosses
   // in the same cycle as the select is always seen first
   wire cs_rise  = cs_s3_r & ~cs_s4_r;
   wire frm_evt  = frm_s2_r ^ frm_s3_r;
   wire ovr_evt  = ovr_s2_r ^ ovr_s3_r;

   // captured frame and its arm flag
   logic [FRAME_W-1:0] word_r;    // frame taken from the link
   logic [FRAME_W-1:0] word_nxt;  // next captured frame
   logic               armed_r;   // a complete frame waits for select rise
   logic               armed_nxt; // next arm state

   // the word is stable behind the toggle, so it is sampled on the event
   assign word_nxt = frm_evt ? lnk.frame_word : word_r;

   // a full frame arms; too many bits, a new frame or the rise disarm
   always_comb begin
      armed_nxt = armed_r;
      if (cs_fall)
         armed_nxt = 1'b0;                     // stale frame dropped
      if (frm_evt)
         armed_nxt = 1'b1;                     // exact 32 bits
      if (ovr_evt)
         armed_nxt = 1'b0;                     // extra bits
      if (cs_rise)
         armed_nxt = 1'b0;                     // used or short
   end

   // capture registers
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         word_r  <= '0;
         armed_r <= 1'b0;
      end else begin
         word_r  <= word_nxt;
         armed_r <= armed_nxt;
      end
   end

   // command decode
   wire [7:0]       opcode   = word_r[OPC_MSB:OPC_LSB];
   wire             is_block = (opcode == OP_BLOCK_ERASE);
   wire             is_sect  = (opcode == OP_SECTOR_ERASE);
   wire [SEL_W-1:0] sel      = page_select(mode_s2_r, word_r);
   wire [19:0]      span     = erase_span(is_sect, sel);
   wire [PAGE_W-1:0] span_first = span[19:9];
   wire [8:0]       span_count = span[8:0];

   // sequencer state
   sfbse_state_e      state_r;    // current state
   sfbse_state_e      state_nxt;  // next state
   logic [PAGE_W-1:0] page_r;     // page to wipe next
   logic [PAGE_W-1:0] page_nxt;   // next page pointer
   logic [8:0]        left_r;     // pages still to wipe
   logic [8:0]        left_nxt;   // next page count
   logic [31:0]       timer_r;    // cycles since the erase began
   logic [31:0]       timer_nxt;  // next timer value
   logic [31:0]       limit_r;    // cycle budget of this erase
   logic [31:0]       limit_nxt;  // next budget
   logic              done_nxt;   // end of erase this cycle

   // start only on the select rise, only when armed, only when idle;
   // a command arriving while busy is dropped, as the array is in use
   wire idle     = (state_r == ST_IDLE);
   wire start    = cs_rise & armed_r & idle &
                   (is_block | is_sect);
   wire time_up  = (timer_r >= limit_r - 32'h1);

   // next-state logic
   always_comb begin
      state_nxt = state_r;
      page_nxt  = page_r;
      left_nxt  = left_r;
      timer_nxt = timer_r + 32'h1;
      limit_nxt = limit_r;
      done_nxt  = 1'b0;
      unique case (state_r)
         ST_IDLE: begin
            timer_nxt = '0;
            if (start) begin
               state_nxt = ST_WIPE;
               page_nxt  = span_first;
               left_nxt  = span_count;
               limit_nxt = is_sect ? SE_CYC : BE_CYC;
            end
         end
         ST_WIPE: begin
            // one page per cycle, far inside any erase budget
            page_nxt = page_r + 11'h001;
            left_nxt = left_r - ONE_PAGE;
            if (left_r == ONE_PAGE)
               state_nxt = ST_HOLD;
         end
         ST_HOLD: begin
            // busy stays up until the self-timed interval runs out
            if (time_up) begin
               state_nxt = ST_IDLE;
               done_nxt  = 1'b1;
            end
         end
         default: begin
            state_nxt = ST_IDLE;                        // illegal code
         end
      endcase
   end

   // sequencer registers
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_r <= ST_IDLE;
         page_r  <= '0;
         left_r  <= '0;
         timer_r <= '0;
         limit_r <= '0;
      end else begin
         state_r <= state_nxt;
         page_r  <= page_nxt;
         left_r  <= left_nxt;
         timer_r <= timer_nxt;
         limit_r <= limit_nxt;
      end
   end

   // outputs, each straight from a flop
   logic              busy_n_r;      // ready/busy pin
   logic              stat_busy_r;   // status busy bit
   logic              wipe_r;        // page strobe
   logic [PAGE_W-1:0] apage_r;       // page under erase
   logic [7:0]        fill_r;        // erase fill value
   logic              done_r;        // completion pulse
   wire               busy_nxt = (state_nxt != ST_IDLE);

   // busy covers the whole operation on both indicators
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         busy_n_r    <= 1'b1;
         stat_busy_r <= 1'b0;
         done_r      <= 1'b0;
      end else begin
         busy_n_r    <= ~busy_nxt;
         stat_busy_r <= busy_nxt;
         done_r      <= done_nxt;
      end
   end

   // array strobes trail the page pointer by one cycle
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wipe_r  <= 1'b0;
         apage_r <= '0;
         fill_r  <= ERASED_BYTE;
      end else begin
         wipe_r  <= (state_r == ST_WIPE);
         apage_r <= page_r;
         fill_r  <= ERASED_BYTE;
      end
   end

   assign busy_n      = busy_n_r;
   assign status_busy = stat_busy_r;
   assign array_wipe  = wipe_r;
   assign array_page  = apage_r;
   assign array_fill  = fill_r;
   assign erase_done  = done_r;

endmodule // sfbse_top
`default_nettype wire

//--- sfbse_top_properties.sv
// timing and value checks on the ports of the erase sequencer top
// assumes binding to sfbse_top, one core clock domain, async reset low
`timescale 1ns/1ps
`default_nettype none
module sfbse_top_properties
   import sfbse_pkg::*;
#(
   parameter int BLOCK_ERASE_MAX_TIME_US  = 1000,  // longest block erase
   parameter int SECTOR_ERASE_MAX_TIME_US = 5000   // longest sector erase
)(
   input wire logic              clk,           // core clock
   input wire logic              reset_n,       // async reset, low
   input wire logic              spi_sck,       // host serial clock
   input wire logic              spi_cs_n,      // chip select, low
   input wire logic              spi_si,        // serial data in
   input wire logic              page_mode_256, // page mode select
   input wire logic              busy_n,        // ready/busy pin
   input wire logic              status_busy,   // status busy bit
   input wire logic              array_wipe,    // page strobe
   input wire logic [PAGE_W-1:0] array_page,    // page being wiped
   input wire logic [7:0]        array_fill,    // erase fill value
   input wire logic              erase_done     // end pulse
);
   // the longest legal busy stretch, sector erase being the longer
   localparam int SE_LIMIT = SECTOR_ERASE_MAX_TIME_US * NS_PER_US / CLK_PERIOD_NS;
   logic [19:0] busy_cnt_r;   // cycles spent busy so far
   logic [19:0] busy_cnt_nxt; // next count

   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);

   // counter restarts whenever busy drops
   assign busy_cnt_nxt = status_busy ? busy_cnt_r + 20'h00001 : 20'h00000;

   // helper count of busy cycles
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         busy_cnt_r <= 20'h00000;
      end else begin
         busy_cnt_r <= busy_cnt_nxt;
      end
   end

   // every erase wipes at least eight pages straight after busy shows
   sequence s_wipe_run;
      array_wipe [*8];
   endsequence

   a_fill_all_ones: assert property (array_fill == ERASED_BYTE)
      else $error("fill value is not all ones");
   a_busy_pins_agree: assert property (busy_n == !status_busy)
      else $error("busy pin and status bit disagree");
   a_wipe_while_busy: assert property (array_wipe |-> status_busy)
      else $error("page strobe outside busy");
   a_busy_starts_wipe: assert property ($rose(status_busy) |=> s_wipe_run)
      else $error("busy without a run of page strobes");
   a_done_ends_busy: assert property (erase_done |-> !status_busy && $past(status_busy))
      else $error("done pulse not at busy release");
   a_done_one_cycle: assert property (erase_done |=> !erase_done)
      else $error("done pulse longer than one cycle");
   a_pages_in_order: assert property (array_wipe && $past(array_wipe)
      |-> array_page == $past(array_page) + 11'h001)
      else $error("page strobes not consecutive");
   a_run_aligned: assert property ($rose(array_wipe) |-> array_page[2:0] == 3'h0)
      else $error("erase run not on an eight page boundary");
   a_busy_after_cs: assert property ($rose(status_busy) |-> spi_cs_n)
      else $error("busy began while select is low");
   a_busy_bounded: assert property (busy_cnt_r <= SE_LIMIT)
      else $error("busy longer than the sector erase limit");
endmodule // sfbse_top_properties

bind sfbse_top sfbse_top_properties #(
   .BLOCK_ERASE_MAX_TIME_US (BLOCK_ERASE_MAX_TIME_US),
   .SECTOR_ERASE_MAX_TIME_US(SECTOR_ERASE_MAX_TIME_US)
) u_props (
   .clk(clk), .reset_n(reset_n), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
   .spi_si(spi_si), .page_mode_256(page_mode_256), .busy_n(busy_n),
   .status_busy(status_busy), .array_wipe(array_wipe), .array_page(array_page),
   .array_fill(array_fill), .erase_done(erase_done)
);
`default_nettype wire

//--- sfbse_host_model.sv
// host controller model: clocks command frames onto the serial link
// assumes mode 0, a 15 ns serial clock that runs only inside frames
`timescale 1ns/1ps
`default_nettype none
module sfbse_host_model (
   output var logic spi_sck,  // serial clock, idle low
   output var logic spi_cs_n, // chip select, idle high
   output var logic spi_si    // serial data, msb first
);
   // link at rest until the first frame
   initial begin
      spi_sck  = 1'b0;
      spi_cs_n = 1'b1;
      spi_si   = 1'b0;
   end

   // sends the top n bits of w, then raises select after a quiet gap
   task automatic send_frame(input logic [32:0] w, input int n);
      int i;
      #37;                           // off the core clock phase
      spi_cs_n = 1'b0;
      #20;
      for (i = 0; i < n; i++) begin  // opcode then address bytes
         spi_si = w[32-i];
         #7.5 spi_sck = 1'b1;
         #7.5 spi_sck = 1'b0;
      end
      #250;                          // over two core clocks to select rise
      spi_si   = ~spi_si;            // released line shows no stale value
      spi_cs_n = 1'b1;               // rising select starts the erase
      #500;                          // select high for several core clocks
   endtask
endmodule // sfbse_host_model
`default_nettype wire

//--- sfbse_top_tb.sv
// self-checking bench for the block and sector erase sequencer
// assumes the host model on the link and shortened erase times
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) samples_checked++; \
   if ((got) !== (ex)) begin \
      $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); \
      fail_count++; \
   end
module sfbse_top_tb;
   import sfbse_pkg::*;
   localparam int BE_US  = 30;                             // short block time
   localparam int SE_US  = 40;                             // short sector time
   localparam int BE_CYC = BE_US * NS_PER_US / CLK_PERIOD_NS;
   localparam int SE_CYC = SE_US * NS_PER_US / CLK_PERIOD_NS;
   logic              clk = 1'b0;           // core clock
   logic              reset_n = 1'b0;       // reset, low
   logic              page_mode_256 = 1'b0; // page mode
   logic              spi_sck;              // from host model
   logic              spi_cs_n;             // from host model
   logic              spi_si;               // from host model
   logic              busy_n;               // ready/busy pin
   logic              status_busy;          // status bit
   logic              array_wipe;           // page strobe
   logic [PAGE_W-1:0] array_page;           // strobed page
   logic [7:0]        array_fill;           // fill value
   logic              erase_done;           // end pulse
   logic [PAGE_W-1:0] first_page;           // first strobed page
   logic [PAGE_W-1:0] last_page;            // last strobed page
   int                wipe_cnt = 0;         // strobes seen
   int                busy_cyc = 0;         // busy cycles seen
   int                done_cnt = 0;         // done pulses seen
   int                fail_count = 0;       // mismatches
   int                samples_checked = 0;  // comparisons

   always #50 clk = ~clk;

   sfbse_host_model HOST (.spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_si(spi_si));

   sfbse_top #(.BLOCK_ERASE_MAX_TIME_US(BE_US), .SECTOR_ERASE_MAX_TIME_US(SE_US)) DUT (
      .clk(clk), .reset_n(reset_n), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
      .spi_si(spi_si), .page_mode_256(page_mode_256), .busy_n(busy_n),
      .status_busy(status_busy), .array_wipe(array_wipe), .array_page(array_page),
      .array_fill(array_fill), .erase_done(erase_done));

   // records what the array and the busy outputs did
   always @(posedge clk) begin
      if (array_wipe === 1'b1) begin
         if (wipe_cnt == 0) first_page <= array_page;
         last_page <= array_page;
         wipe_cnt  <= wipe_cnt + 1;
      end
      if (status_busy === 1'b1) busy_cyc <= busy_cyc + 1;
      if (erase_done === 1'b1) done_cnt <= done_cnt + 1;
   end

   task automatic tally_and_finish();
      if (fail_count == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // sends a frame in the given mode after clearing the records
   task automatic frame(input logic mode, input logic [32:0] w, input int n);
      @(posedge clk) page_mode_256 <= mode;
      repeat (3) @(posedge clk);     // mode passes its synchroniser
      @(negedge clk);
      wipe_cnt = 0; busy_cyc = 0; done_cnt = 0;
      HOST.send_frame(w, n);
   endtask

   // full erase, then the strobed page range and busy length judged
   task automatic do_erase(input logic mode, input logic [7:0] op, input logic [23:0] addr,
                           input logic [PAGE_W-1:0] ex_first, input int ex_n, input int lim);
      int i;
      frame(mode, {op, addr, 1'b0}, 32);
      i = 0;
      while (!(busy_cyc > 0 && status_busy === 1'b0) && i < lim + 100) begin
         @(posedge clk);
         i++;
      end
      if (i >= lim + 100) begin  // erase never ran or never ended
         fail_count++;
         tally_and_finish();
      end
      repeat (2) @(posedge clk);
      #1;
      `CHK("first_page", ex_first, first_page)
      `CHK("last_page", ex_first + 11'(ex_n - 1), last_page)
      `CHK("wipe_count", ex_n, wipe_cnt)
      `CHK("busy_length", 1'b1, (busy_cyc >= lim - 2 && busy_cyc <= lim))
      `CHK("done_pulses", 1, done_cnt)
      `CHK("fill", ERASED_BYTE, array_fill)
      `CHK("busy_pin", 1'b1, busy_n)
   endtask

   // frames that must change nothing
   task automatic refused(input logic [32:0] w, input int n);
      frame(1'b0, w, n);
      repeat (20) @(posedge clk);
      `CHK("refused_busy", 0, busy_cyc)
      `CHK("refused_wipes", 0, wipe_cnt)
   endtask

   // block erase in both page modes, ignored bits all ones
   task automatic s_block_erase();
      do_erase(1'b0, OP_BLOCK_ERASE, {4'hf, 8'h05, 12'hfff}, 11'd40, 8, BE_CYC);
      do_erase(1'b1, OP_BLOCK_ERASE, {5'h1f, 8'hff, 11'h7ff}, 11'd2040, 8, BE_CYC);
      do_erase(1'b0, OP_BLOCK_ERASE, {4'hf, 8'h00, 12'hfff}, 11'd0, 8, BE_CYC);
   endtask

   // sectors one to seven, alternating page modes
   task automatic s_sector_erase();
      logic [2:0] k;
      for (int s = 1; s < 8; s++) begin
         k = 3'(s);
         if (k[0]) begin
            do_erase(1'b1, OP_SECTOR_ERASE, {5'h1f, k, 16'hffff}, {k, 8'h00}, 256, SE_CYC);
         end else begin
            do_erase(1'b0, OP_SECTOR_ERASE, {4'hf, k, 17'h1ffff}, {k, 8'h00}, 256, SE_CYC);
         end
      end
   endtask

   // the split sector zero halves
   task automatic s_sector_zero();
      do_erase(1'b0, OP_SECTOR_ERASE, {4'hf, 8'h00, 12'hfff}, 11'd0, 8, SE_CYC);
      do_erase(1'b1, OP_SECTOR_ERASE, {5'h1f, 8'h01, 11'h7ff}, 11'd8, 248, SE_CYC);
   endtask

   // short, long and foreign frames
   task automatic s_refused();
      refused({OP_BLOCK_ERASE, 24'h005000, 1'b0}, 31);
      refused({OP_BLOCK_ERASE, 24'h005000, 1'b1}, 33);
      refused({8'h81, 24'h005000, 1'b0}, 32);
   endtask

   // reset, then every scenario in turn
   initial begin
      repeat (16) @(posedge clk);
      #1;
      `CHK("reset_busy_pin", 1'b1, busy_n)
      `CHK("reset_status", 1'b0, status_busy)
      `CHK("reset_done", 1'b0, erase_done)
      @(posedge clk) reset_n <= 1'b1;
      repeat (4) @(posedge clk);
      s_block_erase();
      s_sector_zero();
      s_sector_erase();
      s_refused();
      tally_and_finish();
   end
endmodule // sfbse_top_tb
`default_nettype wire
